// *** hdl/jfu_pkg.sv ***
// package: constants, modes and lane-to-sample mapping shared by both ends
// Contract
// - mode 3: lane n is converter n, MSB first
// - mode 4: lane n is converter n, MSB first
// - mode 9: lane pairs split converter samples alternately
// - mode 14 maps exactly like mode 9
// - mode 16: lane k holds samples k, k+4
// - mode 5: six nibbles, converter 0 then 1
// - mode 6: lane n holds converters 2n, 2n+1
// - mode 17: lane j holds samples 2j, 2j+1
// - 11-bit in 16-bit word: bits 4..0 zero
// - 11-bit in 12-bit word: bit 0 zero
// - samples indexed by converter and sample position
// - 32 frames per multiframe, mapping repeats
package jfu_pkg;
  localparam int LANES      = 8;              // lanes of the widest mode
  localparam int OCT_W      = 8;              // octet width
  localparam int FRM_OCT    = 3;              // octet slots carried per lane per frame
  localparam int LANE_W     = OCT_W*FRM_OCT;  // lane word: octet 0 in the top byte
  localparam int LINK_W     = LANES*LANE_W;   // whole frame across all lanes
  localparam int CONVS      = 4;              // converter slots
  localparam int SAMPS      = 8;              // sample slots per converter
  localparam int SLOTS      = CONVS*SAMPS;    // slot index = conv*SAMPS + sample
  localparam int SMP_W      = 16;             // slot width
  localparam int OUT_W      = SLOTS*SMP_W;    // all slots in parallel
  localparam int FRAMES_MF  = 32;             // frames per multiframe
  localparam int FIFO_DEPTH = 8;              // words buffered toward the datapath
  localparam int MODE_W     = 5;              // operating mode number width
  localparam logic [MODE_W-1:0] MODE_3  = 5'h03;
  localparam logic [MODE_W-1:0] MODE_4  = 5'h04;
  localparam logic [MODE_W-1:0] MODE_5  = 5'h05;
  localparam logic [MODE_W-1:0] MODE_6  = 5'h06;
  localparam logic [MODE_W-1:0] MODE_9  = 5'h09;
  localparam logic [MODE_W-1:0] MODE_14 = 5'h0e;
  localparam logic [MODE_W-1:0] MODE_16 = 5'h10;
  localparam logic [MODE_W-1:0] MODE_17 = 5'h11;
  localparam logic [SMP_W-1:0] PAD16_MASK = 16'hffe0; // 11-bit data in 16-bit word
  localparam logic [SMP_W-1:0] PAD12_MASK = 16'h0ffe; // 11-bit data in 12-bit word
  localparam logic [SMP_W-1:0] NP12_MASK  = 16'h0fff; // 12-bit packing, low bits

  // three-octet frames carry two 12-bit samples per lane
  function automatic logic is_f3(input logic [MODE_W-1:0] m);
    is_f3 = (m == MODE_5) || (m == MODE_6) || (m == MODE_17);
  endfunction : is_f3

  // lanes in use by a mode; zero for a mode this block does not map
  function automatic logic [3:0] lanes_of(input logic [MODE_W-1:0] m);
    case (m)
      MODE_5:                   lanes_of = 4'h1;
      MODE_3, MODE_6:           lanes_of = 4'h2;
      MODE_4, MODE_9, MODE_14:  lanes_of = 4'h4;
      MODE_16, MODE_17:         lanes_of = 4'h8;
      default:                  lanes_of = 4'h0;
    endcase
  endfunction : lanes_of

  // slot for lane, half (0 upper, 1 lower 12-bit word) and frame phase
  function automatic logic [4:0] slot_of(input logic [MODE_W-1:0] m,
                                         input logic [2:0] ln,
                                         input logic hf,
                                         input logic ph);
    logic [1:0] cv;
    logic [2:0] sm;
    cv = 2'h0;
    sm = 3'h0;
    // converter number carried by this lane and half
    case (m)
      MODE_3, MODE_4:  cv = ln[1:0];
      MODE_9, MODE_14: cv = {1'b0, ln[1]};
      MODE_16:         cv = {1'b0, ln[2]};
      MODE_5, MODE_6:  cv = {ln[0], hf};
      MODE_17:         cv = {1'b0, ln[2]};
      default:         cv = 2'h0;
    endcase
    // sample position within the frame; one sample per frame in modes 5 and 6
    case (m)
      MODE_3, MODE_4:  sm = {2'h0, ph};
      MODE_9, MODE_14: sm = {1'b0, ph, ln[0]};
      MODE_16:         sm = {ph, ln[1:0]};
      MODE_17:         sm = {ln[1:0], hf};
      default:         sm = 3'h0;
    endcase
    slot_of = {cv, sm};
  endfunction : slot_of

  // mask of the bits a sample may carry in this mode
  function automatic logic [SMP_W-1:0] mask_of(input logic [MODE_W-1:0] m);
    case (m)
      MODE_14, MODE_16: mask_of = PAD16_MASK;
      MODE_17:          mask_of = PAD12_MASK;
      MODE_5, MODE_6:   mask_of = NP12_MASK;
      default:          mask_of = 16'hffff;
    endcase
  endfunction : mask_of
endpackage : jfu_pkg

// *** hdl/jfu_link_if.sv ***
// interface: frame-parallel lane octets between transmitter and unpacker
`timescale 1ns/1ps
`default_nettype none
interface jfu_link_if;
  logic [jfu_pkg::LINK_W-1:0] lane_data;   // lane l at [l*24 +: 24], octet 0 on top
  logic                       frame_valid; // a whole frame is on lane_data
  logic                       frame_ready; // unpacker can take the frame
  logic                       link_sync;   // receiver reports the link synchronized

  modport dev (input lane_data, input frame_valid, output frame_ready, output link_sync);
  modport tx  (output lane_data, output frame_valid, input frame_ready, input link_sync);
endinterface : jfu_link_if
`default_nettype wire

// *** hdl/jfu_unpacker.sv ***
// file: sample FIFO and the receiving transport-layer unpacker
`timescale 1ns/1ps
`default_nettype none

// synchronous FIFO with valid/ready on both sides
module jfu_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             rst_n_in,
  input  wire logic             flush_in,
  // fill side
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  // drain side
  output logic [WIDTH-1:0]      out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];    // storage
  logic [AW-1:0]    wr_ptr_ff;         // write index
  logic [AW-1:0]    rd_ptr_ff;         // read index
  logic [AW:0]      count_ff;          // words held
  wire              push;              // word accepted
  wire              pop;               // word delivered

  assign in_ready_out  = (count_ff != (AW+1)'(DEPTH));
  assign out_valid_out = (count_ff != '0);
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;
  assign out_data_out  = mem_ff[rd_ptr_ff];

  // pointers and count; flush empties the buffer
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in || flush_in)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end
    else
    begin
      if (push) wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      if (pop)  rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // storage write, no reset needed
  always_ff @(posedge clk_sys_in)
  begin
    if (push) mem_ff[wr_ptr_ff] <= in_data_in;
  end
endmodule : jfu_fifo

// receiving end: maps lane octets to converter sample slots
module jfu_unpacker (
  // clock and reset
  input  wire logic                          clk_sys_in,
  input  wire logic                          rst_n_in,
  // configuration and link state from the data link layer
  input  wire logic [jfu_pkg::MODE_W-1:0]    mode_in,
  input  wire logic                          link_up_in,
  // link side
  jfu_link_if.dev                            link,
  // datapath side
  output logic [jfu_pkg::OUT_W-1:0]          smp_data_out,
  output logic                               smp_phase_out,
  output logic                               smp_valid_out,
  input  wire logic                          smp_ready_in,
  output logic [jfu_pkg::MODE_W-1:0]         mode_out,
  output logic                               mode_bad_out
);
  logic [jfu_pkg::MODE_W-1:0] mode_ff;        // active mapping
  logic                       sync_ff;        // link synchronized
  logic                       phase_ff;       // even/odd frame
  logic [4:0]                 mf_cnt_ff;      // frame in multiframe
  logic [jfu_pkg::SMP_W-1:0]  slot_v [jfu_pkg::SLOTS]; // unpacked frame
  logic [jfu_pkg::OUT_W-1:0]  frame_word;     // slots flattened
  logic                       fifo_in_ready;  // buffer room
  wire                        take;           // frame accepted
  wire                        mode_ok;        // mode is mapped

  assign mode_ok          = (jfu_pkg::lanes_of(mode_ff) != 4'h0);
  assign link.link_sync   = sync_ff;
  assign link.frame_ready = sync_ff && fifo_in_ready;                     // back-pressure
  assign take             = link.frame_valid && link.frame_ready && mode_ok;
  assign mode_out         = mode_ff;
  assign mode_bad_out     = !mode_ok;

  // mode may change only while the link is down
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      mode_ff <= jfu_pkg::MODE_3;
    else if (!sync_ff && !link_up_in)
      mode_ff <= mode_in;
  end

  // synchronized state and frame position in the multiframe
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      sync_ff   <= 1'b0;
      phase_ff  <= 1'b0;
      mf_cnt_ff <= 5'h00;
    end
    else if (!link_up_in)
    begin
      sync_ff   <= 1'b0;   // lost link restarts framing
      phase_ff  <= 1'b0;
      mf_cnt_ff <= 5'h00;
    end
    else
    begin
      sync_ff <= 1'b1;
      if (take)
      begin
        // even frame count, so phase restarts in step at each multiframe
        mf_cnt_ff <= (mf_cnt_ff == 5'(jfu_pkg::FRAMES_MF-1)) ? 5'h00 : mf_cnt_ff + 5'h01;
        phase_ff  <= (mf_cnt_ff == 5'(jfu_pkg::FRAMES_MF-1)) ? 1'b0 : !phase_ff;
      end
    end
  end

  // scatter each lane word into its slots; unused slots read zero
  always_comb
  begin
    logic [jfu_pkg::LANE_W-1:0] lw;
    logic [4:0]                 s;
    lw = '0;
    s  = '0;
    for (int i = 0; i < jfu_pkg::SLOTS; i++) slot_v[i] = '0;
    for (int l = 0; l < jfu_pkg::LANES; l++)
    begin
      lw = link.lane_data[l*jfu_pkg::LANE_W +: jfu_pkg::LANE_W];
      if (4'(l) < jfu_pkg::lanes_of(mode_ff))
      begin
        if (jfu_pkg::is_f3(mode_ff))
        begin
          // six nibbles most significant first: two 12-bit words
          s = jfu_pkg::slot_of(mode_ff, 3'(l), 1'b0, phase_ff);
          slot_v[s] = {4'h0, lw[23:12]};
          s = jfu_pkg::slot_of(mode_ff, 3'(l), 1'b1, phase_ff);
          slot_v[s] = {4'h0, lw[11:0]};
        end
        else
        begin
          // octet 0 upper byte, octet 1 lower byte
          s = jfu_pkg::slot_of(mode_ff, 3'(l), 1'b0, phase_ff);
          slot_v[s] = lw[23:8];
        end
      end
    end
  end

  // flatten slots: slot i at [i*16 +: 16]
  genvar g;
  generate
    for (g = 0; g < jfu_pkg::SLOTS; g++)
    begin : g_flat
      assign frame_word[g*jfu_pkg::SMP_W +: jfu_pkg::SMP_W] = slot_v[g];
    end
  endgenerate

  // buffered toward the datapath, emptied when the link drops
  logic [jfu_pkg::OUT_W:0] fifo_out;      // phase tag on top
  logic                    fifo_out_valid;
  jfu_fifo #(
    .WIDTH (jfu_pkg::OUT_W+1),
    .DEPTH (jfu_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in    (clk_sys_in),
    .rst_n_in      (rst_n_in),
    .flush_in      (!sync_ff),
    .in_data_in    ({phase_ff, frame_word}),
    .in_valid_in   (take),
    .in_ready_out  (fifo_in_ready),
    .out_data_out  (fifo_out),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (smp_ready_in)
  );

  assign smp_data_out  = fifo_out[jfu_pkg::OUT_W-1:0];
  assign smp_phase_out = fifo_out[jfu_pkg::OUT_W];
  assign smp_valid_out = fifo_out_valid && sync_ff;
endmodule : jfu_unpacker
`default_nettype wire

// *** hdl/jfu_packer.sv ***
// file: transmitting end, packs converter samples into lane octets
`timescale 1ns/1ps
`default_nettype none
module jfu_packer (
  // clock and reset
  input  wire logic                       clk_sys_in,
  input  wire logic                       rst_n_in,
  // configuration
  input  wire logic [jfu_pkg::MODE_W-1:0] mode_in,
  // user side: one frame of slots
  input  wire logic [jfu_pkg::OUT_W-1:0]  smp_data_in,
  input  wire logic                       smp_valid_in,
  output logic                            smp_ready_out,
  output logic                            smp_phase_out,
  // link side
  jfu_link_if.tx                          link
);
  logic [jfu_pkg::MODE_W-1:0] mode_ff;     // mapping in use
  logic                       phase_ff;    // even/odd frame
  logic [4:0]                 mf_cnt_ff;   // frame in multiframe
  logic [jfu_pkg::LINK_W-1:0] lanes_ff;    // registered frame
  logic                       valid_ff;    // frame on the link
  logic [jfu_pkg::LINK_W-1:0] nxt_lanes;   // packed frame
  wire                        sent;        // frame taken by receiver
  wire                        load;        // new frame loaded

  assign sent          = valid_ff && link.frame_ready;
  assign smp_ready_out = link.link_sync && (!valid_ff || link.frame_ready);
  assign load          = smp_valid_in && smp_ready_out;
  assign link.lane_data   = lanes_ff;
  assign link.frame_valid = valid_ff;
  assign smp_phase_out    = phase_ff;

  // gather samples into lane words, padding bits forced to zero
  always_comb
  begin
    logic [jfu_pkg::SMP_W-1:0] a;
    logic [jfu_pkg::SMP_W-1:0] b;
    logic [4:0]                s;
    a = '0;
    b = '0;
    s = '0;
    nxt_lanes = '0;
    for (int l = 0; l < jfu_pkg::LANES; l++)
    begin
      if (4'(l) < jfu_pkg::lanes_of(mode_ff))
      begin
        s = jfu_pkg::slot_of(mode_ff, 3'(l), 1'b0, phase_ff);
        a = smp_data_in[s*jfu_pkg::SMP_W +: jfu_pkg::SMP_W] & jfu_pkg::mask_of(mode_ff);
        s = jfu_pkg::slot_of(mode_ff, 3'(l), 1'b1, phase_ff);
        b = smp_data_in[s*jfu_pkg::SMP_W +: jfu_pkg::SMP_W] & jfu_pkg::mask_of(mode_ff);
        if (jfu_pkg::is_f3(mode_ff))
          nxt_lanes[l*jfu_pkg::LANE_W +: jfu_pkg::LANE_W] = {a[11:0], b[11:0]};
        else
          nxt_lanes[l*jfu_pkg::LANE_W +: jfu_pkg::LANE_W] = {a, 8'h00};
      end
    end
  end

  // mode held while synchronized
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      mode_ff <= jfu_pkg::MODE_3;
    else if (!link.link_sync)
      mode_ff <= mode_in;
  end

  // frame register and multiframe position
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in || !link.link_sync)
    begin
      lanes_ff  <= '0;
      valid_ff  <= 1'b0;
      phase_ff  <= 1'b0;
      mf_cnt_ff <= 5'h00;
    end
    else
    begin
      if (load)
      begin
        lanes_ff  <= nxt_lanes;
        mf_cnt_ff <= (mf_cnt_ff == 5'(jfu_pkg::FRAMES_MF-1)) ? 5'h00 : mf_cnt_ff + 5'h01;
        phase_ff  <= (mf_cnt_ff == 5'(jfu_pkg::FRAMES_MF-1)) ? 1'b0 : !phase_ff;
      end
      if (load)
        valid_ff <= 1'b1;
      else if (sent)
        valid_ff <= 1'b0;
    end
  end
endmodule : jfu_packer
`default_nettype wire

// *** sim/jfu_link_checker.sv ***
// checker: concurrent assertions on the lane interface between packer and unpacker
`timescale 1ns/1ps
`default_nettype none
module jfu_link_checker (
  // clock and reset
  input  wire logic                       clk_sys_in,
  input  wire logic                       rst_n_in,
  // interface signals and latched mode
  input  wire logic [jfu_pkg::LINK_W-1:0] lane_data_in,
  input  wire logic                       frame_valid_in,
  input  wire logic                       frame_ready_in,
  input  wire logic                       link_sync_in,
  input  wire logic [jfu_pkg::MODE_W-1:0] mode_in
);
  logic f2_ok;  // unused low octet of two-octet frames is zero
  logic pad_ok; // padding bits of 11-bit samples are zero

  // per-lane checks over the lanes the latched mode uses
  always_comb
  begin
    f2_ok  = 1'b1;
    pad_ok = 1'b1;
    for (int l = 0; l < 8; l++)
    begin
      // two-octet modes: third octet slot unused
      if (((mode_in == jfu_pkg::MODE_3) && (l < 2)) || ((l < 4) &&
          ((mode_in == jfu_pkg::MODE_4) || (mode_in == jfu_pkg::MODE_9) ||
           (mode_in == jfu_pkg::MODE_14))) || (mode_in == jfu_pkg::MODE_16))
        f2_ok = f2_ok && (lane_data_in[l*24 +: 8] == 8'h00);
      // 16-bit packing of 11-bit data: five low bits zero
      if (((mode_in == jfu_pkg::MODE_14) && (l < 4)) || (mode_in == jfu_pkg::MODE_16))
        pad_ok = pad_ok && (lane_data_in[l*24+8 +: 5] == 5'h00);
      // 12-bit packing of 11-bit data: bit 0 of both words zero
      if (mode_in == jfu_pkg::MODE_17)
        pad_ok = pad_ok && !lane_data_in[l*24] && !lane_data_in[l*24+12];
    end
  end

  // a frame offered on a synchronized link but not yet taken;
  // a link loss may withdraw the offer, so it is left out here
  sequence s_offer;
    frame_valid_in && !frame_ready_in && link_sync_in;
  endsequence

  a_offer_holds: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    s_offer |=> frame_valid_in) else $error("frame withdrawn before taken");
  a_data_holds: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    s_offer |=> $stable(lane_data_in)) else $error("lane data changed before taken");
  a_ready_sync: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    frame_ready_in |-> link_sync_in) else $error("frame ready while not synced");
  a_reset_idle: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(rst_n_in) |-> !link_sync_in && !frame_valid_in && (lane_data_in == '0))
    else $error("interface not idle after reset");
  a_sync_first: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(link_sync_in) |-> !frame_valid_in) else $error("frame offered before sync");
  a_rise_ready: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(link_sync_in) |-> frame_ready_in) else $error("no room when link synced");
  a_f2_low_zero: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    frame_valid_in |-> f2_ok) else $error("unused octet not zero");
  a_pad_zero: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    frame_valid_in |-> pad_ok) else $error("padding bits not zero");
endmodule : jfu_link_checker
`default_nettype wire

// *** sim/jfu_f2_f3_sample_unpacker_test.sv ***
// testbench: packer and unpacker back to back over the lane interface
`timescale 1ns/1ps
`default_nettype none
module jesd_f2_f3_sample_unpacker_test;
  logic                         clk_sys_in = 1'b0;  // 10 MHz system clock
  logic                         rst_n_in   = 1'b0;  // synchronous reset
  logic [jfu_pkg::MODE_W-1:0]   mode_in    = jfu_pkg::MODE_3;
  logic                         link_up_in = 1'b0;  // data link layer lock
  logic [jfu_pkg::OUT_W-1:0]    smp_data_in = '0;   // packer user data
  logic                         smp_valid_in = 1'b0;
  logic                         smp_ready_in = 1'b1; // unpacker user ready
  logic                         tx_ready, tx_phase, rx_phase, rx_valid, mode_bad;
  logic [jfu_pkg::OUT_W-1:0]    rx_data;
  logic [jfu_pkg::MODE_W-1:0]   mode_lat;
  logic [jfu_pkg::OUT_W-1:0]    oq[$];              // words seen at the datapath
  logic                         pq[$];              // their phase tags
  logic [jfu_pkg::LINK_W-1:0]   lq[$];              // frames seen on the wire
  int                           n_mismatch = 0;
  int                           cmp_count  = 0;
  int                           cyc        = 0;

  jfu_link_if link ();
  jfu_packer u_jfu_packer (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .mode_in(mode_in),
    .smp_data_in(smp_data_in), .smp_valid_in(smp_valid_in), .smp_ready_out(tx_ready),
    .smp_phase_out(tx_phase), .link(link));
  jfu_unpacker u_jfu_unpacker (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .mode_in(mode_in),
    .link_up_in(link_up_in), .link(link), .smp_data_out(rx_data), .smp_phase_out(rx_phase),
    .smp_valid_out(rx_valid), .smp_ready_in(smp_ready_in), .mode_out(mode_lat),
    .mode_bad_out(mode_bad));
  jfu_link_checker u_jfu_link_checker (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .lane_data_in(link.lane_data), .frame_valid_in(link.frame_valid),
    .frame_ready_in(link.frame_ready), .link_sync_in(link.link_sync), .mode_in(mode_lat));

  // clock generator
  always #50 clk_sys_in = ~clk_sys_in;

  // monitors of wire takes and datapath pops, plus the hang limit
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (link.frame_valid === 1'b1 && link.frame_ready === 1'b1)
      lq.push_back(link.lane_data);
    if (rx_valid === 1'b1 && smp_ready_in === 1'b1)
    begin
      oq.push_back(rx_data);
      pq.push_back(rx_phase);
    end
    if (cyc == 20000)
    begin
      n_mismatch++;
      results();
    end
  end

  // compare tasks: wide datapath words and short values
  task automatic cmp_w(input logic [jfu_pkg::OUT_W-1:0] e, input logic [jfu_pkg::OUT_W-1:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp_w
  task automatic cmp_s(input logic [23:0] e, input logic [23:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp_s

  // slot value of slot i in frame n
  function automatic logic [15:0] sv(input int i, input int n);
    sv = 16'(16'h1357 + i*16'h0e2b + n*16'h03a1);
  endfunction : sv
  // lanes, packing and carried bits of each mode
  function automatic int nl(input logic [4:0] m);
    nl = (m == 5'h05) ? 1 : (m == 5'h03 || m == 5'h06) ? 2 : (m >= 5'h10) ? 8 : 4;
  endfunction : nl
  function automatic logic [15:0] msk(input logic [4:0] m);
    msk = (m == 5'h0e || m == 5'h10) ? 16'hffe0 : (m == 5'h11) ? 16'h0ffe :
          (m == 5'h05 || m == 5'h06) ? 16'h0fff : 16'hffff;
  endfunction : msk
  // slot index conv*8+sample for lane l, frame phase ph, half hf
  function automatic int slot(input logic [4:0] m, input int l, input int ph, input int hf);
    case (m)
      5'h09, 5'h0e: slot = (l/2)*8 + l%2 + 2*ph;
      5'h10:        slot = (l/4)*8 + l%4 + 4*ph;
      5'h05, 5'h06: slot = (2*l + hf)*8;
      5'h11:        slot = (l/4)*8 + 2*(l%4) + hf;
      default:      slot = l*8 + ph;
    endcase
  endfunction : slot

  // offer frame n to the packer and hold it until taken
  task automatic push(input int n);
    @(negedge clk_sys_in);
    for (int i = 0; i < 32; i++)
      smp_data_in[i*16 +: 16] = sv(i, n);
    smp_valid_in = 1'b1;
    #1;
    while (tx_ready !== 1'b1)
    begin
      @(negedge clk_sys_in);
      #1;
    end
    cmp_s(24'(n % 2), {23'h0, tx_phase});
  endtask : push

  // bring the link up in mode m, then move mode_in away
  task automatic setup(input logic [4:0] m);
    int k;
    @(negedge clk_sys_in);
    smp_valid_in = 1'b0;
    link_up_in = 1'b0;
    mode_in = m;
    repeat (3) @(negedge clk_sys_in);
    link_up_in = 1'b1;
    k = 0;
    while (link.link_sync !== 1'b1 && k < 20)
    begin
      @(negedge clk_sys_in);
      k++;
    end
    mode_in = (m == 5'h03) ? 5'h04 : 5'h03;
  endtask : setup

  // wait for cnt words, then judge wire and datapath of each frame
  task automatic check(input logic [4:0] m, input int cnt);
    logic [jfu_pkg::OUT_W-1:0] ex;
    logic [15:0] v;
    int k, s, ph;
    @(negedge clk_sys_in);
    smp_valid_in = 1'b0;
    k = 0;
    while (oq.size() < cnt && k < 100)
    begin
      @(negedge clk_sys_in);
      k++;
    end
    cmp_s(24'(cnt), 24'(oq.size()));
    cmp_s(24'(cnt), 24'(lq.size()));
    cmp_s({19'h0, m}, {19'h0, mode_lat});
    cmp_s(24'h0, {23'h0, mode_bad});
    for (int n = 0; n < cnt && oq.size() > 0 && lq.size() > 0; n++)
    begin
      ph = n % 2;
      ex = '0;
      for (int l = 0; l < nl(m); l++)
        for (int hf = 0; hf < ((m == 5'h05 || m == 5'h06 || m == 5'h11) ? 2 : 1); hf++)
        begin
          s = slot(m, l, ph, hf);
          v = sv(s, n) & msk(m);
          ex[s*16 +: 16] = v;
          if (msk(m)[15])
            cmp_s({v, 8'h00}, lq[0][l*24 +: 24]);
          else
            cmp_s(24'(v[11:0]), 24'(lq[0][l*24 + 12*(1-hf) +: 12]));
        end
      cmp_w(ex, oq.pop_front());
      cmp_s(24'(ph), {23'h0, pq.pop_front()});
      void'(lq.pop_front());
    end
    oq.delete();
    lq.delete();
    pq.delete();
  endtask : check

  // every mode; mode 3 runs across a multiframe boundary
  task automatic run_modes();
    logic [4:0] modes [8] = '{5'h03, 5'h04, 5'h05, 5'h06, 5'h09, 5'h0e, 5'h10, 5'h11};
    foreach (modes[j])
    begin
      setup(modes[j]);
      for (int n = 0; n < ((j == 0) ? 34 : 4); n++)
        push(n);
      check(modes[j], (j == 0) ? 34 : 4);
    end
  endtask : run_modes

  // stall the datapath until the buffer refuses, then drain it
  task automatic fill_drain();
    setup(5'h04);
    smp_ready_in = 1'b0;
    for (int n = 0; n < 9; n++)
      push(n);
    repeat (3) @(negedge clk_sys_in);
    cmp_s(24'h0, {23'h0, link.frame_ready});
    cmp_s(24'h1, {23'h0, link.frame_valid});
    smp_ready_in = 1'b1;
    check(5'h04, 9);
  endtask : fill_drain

  // link loss flushes a buffered word; an unmapped mode is flagged and dropped
  task automatic loss_and_bad();
    setup(5'h09);
    push(0);
    check(5'h09, 1);
    smp_ready_in = 1'b0;
    push(1);
    @(negedge clk_sys_in);
    smp_valid_in = 1'b0;
    repeat (2) @(negedge clk_sys_in);
    cmp_s(24'h1, {23'h0, rx_valid});
    link_up_in = 1'b0;
    repeat (3) @(negedge clk_sys_in);
    cmp_s(24'h0, {23'h0, rx_valid});
    cmp_s(24'h0, {23'h0, link.link_sync});
    smp_ready_in = 1'b1;
    setup(5'h00);
    push(0);
    @(negedge clk_sys_in);
    smp_valid_in = 1'b0;
    repeat (3) @(negedge clk_sys_in);
    cmp_s(24'h0, 24'(oq.size()));
    cmp_s(24'h1, {23'h0, mode_bad});
  endtask : loss_and_bad

  // verdict and end of run
  task automatic results();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results

  // main sequence
  initial
  begin
    repeat (12) @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    run_modes();
    fill_drain();
    loss_and_bad();
    results();
  end
endmodule : jesd_f2_f3_sample_unpacker_test
`default_nettype wire
